// ==== rtl/tcor_pkg.sv ====
// Package: register map, field layouts and bundles for the touch calibration/output bank
package tcor_pkg;

  // ==========================================================================
  // Register addresses (8-bit register index on the serial host port)
  localparam logic [7:0] ADDR_CAL_FREEZE_1  = 8'h14;
  localparam logic [7:0] ADDR_CAL_FREEZE_2  = 8'h15;
  localparam logic [7:0] ADDR_CAL_FREEZE_3  = 8'h16;
  localparam logic [7:0] ADDR_NOISE_THRESH  = 8'h17;
  localparam logic [7:0] ADDR_TOUCH_RES_1   = 8'h20;
  localparam logic [7:0] ADDR_TOUCH_RES_2   = 8'h21;
  localparam logic [7:0] ADDR_TOUCH_RES_3   = 8'h22;
  localparam logic [7:0] ADDR_REF_VAL_HIGH  = 8'h23;
  localparam logic [7:0] ADDR_REF_VAL_LOW   = 8'h24;
  localparam logic [7:0] ADDR_REF_TGT_1     = 8'h25;
  localparam logic [7:0] ADDR_REF_TGT_2     = 8'h26;
  localparam logic [7:0] ADDR_REF_TGT_3     = 8'h27;
  localparam logic [7:0] ADDR_SENS_SEL      = 8'h28;
  localparam logic [7:0] ADDR_SENS_VAL      = 8'h29;

  // ==========================================================================
  // Widths and field layouts
  localparam int NUM_CH        = 21;   // Index 0 is the dummy channel
  localparam int REF_W         = 14;
  localparam int REF_HIGH_W    = 6;
  localparam int SENS_W        = 8;
  localparam int SEL_W         = 5;
  localparam int NOISE_LVL_W   = 2;
  localparam int NOISE_CNT_W   = 3;
  localparam int NOISE_CNT_LSB = 2;
  localparam int NOISE_FLAG_BIT = 5;
  localparam int REF_CMD_BIT   = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]             RST_ZERO      = 8'h00;
  localparam logic [NOISE_LVL_W-1:0] RST_NOISE_LVL = 2'h1;
  localparam logic [NOISE_CNT_W-1:0] RST_NOISE_CNT = 3'h3;

  // Selector code gap between channel 7 and channel 8
  localparam logic [SEL_W-1:0] SEL_CH7    = 5'h07;
  localparam logic [SEL_W-1:0] SEL_UNUSED = 5'h08;
  localparam logic [SEL_W-1:0] SEL_CH20   = 5'h15;

  // ==========================================================================
  // Host register port bundle
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tcor_host_req_t;

  // Reference write to the calibration engine
  typedef struct packed {
    logic               strobe;
    logic [NUM_CH-1:0]  target;
    logic [REF_W-1:0]   value;
  } tcor_ref_wr_t;

endpackage : tcor_pkg

// ==== rtl/tcor_regs.sv ====
// Calibration freeze, noise threshold, touch result and reference write register bank
//
// Behaviour
// - Each channel and the dummy has its own freeze bit, 0 lets calibration run, 1 stops it.
// - Freeze bits sit in three registers: dummy then ch1-7, ch8-14 at bits 1-7, ch15-20 low.
// - Noise control has a 2-bit detection level field resetting to 01.
// - Noise control has a 3-bit detection count field resetting to 011.
// - Touch results of the twenty channels read as one read-only bit each over three registers.
// - Bit 5 of the third result register shows the noise flag, 1 when noisy.
// - A 14-bit reference count is held, upper six bits in one register, lower eight in the next.
// - Three select registers mark which channels and dummy take the next reference write.
// - Writing 1 to bit 7 of the last select register loads the count into selected channels.
// - While the command bit reads 1, writes to the reference count are refused.
// - A 5-bit selector picks the channel whose sensitivity is read back, code 8 is unused.
// - The sensitivity data register returns the selected channel's 8-bit sensitivity.
// - All registers take their defaults at reset.
`timescale 1ns/100ps
module tcor_regs #(
  parameter int NCH = 20
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire tcor_pkg::tcor_host_req_t hostReq,
  output logic      [7:0]             rdData,
  input  wire logic [NCH-1:0]         touchIn,
  input  wire logic                   noiseIn,
  input  wire logic [NCH*8-1:0]       sensAll,
  input  wire logic                   refWrDone,
  output logic      [NCH:0]           calFreeze,
  output logic      [1:0]             noiseLevel,
  output logic      [2:0]             noiseCount,
  output tcor_pkg::tcor_ref_wr_t      refWr
);
  import tcor_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0]      freeze;
    logic [NOISE_LVL_W-1:0] nLevel;
    logic [NOISE_CNT_W-1:0] nCount;
    logic [NUM_CH-2:0]      touchSync1;
    logic [NUM_CH-2:0]      touch;
    logic                   noiseSync1;
    logic                   noise;
    logic [REF_HIGH_W-1:0]  refHigh;
    logic [7:0]             refLow;
    logic [NUM_CH-1:0]      target;
    logic                   cmd;
    logic                   strobe;
    logic [SEL_W-1:0]       sensSel;
    logic [7:0]             rd;
  } tcor_regs_state_t;

  tcor_regs_state_t s_reg;
  tcor_regs_state_t s_next;
  logic [SENS_W-1:0] sensData;
  logic              wr;

  // ==========================================================================
  // Sensitivity readback
  tcor_sens_mux #(
    .NCH (NCH),
    .SW  (SENS_W)
  ) u_sens_mux (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .chanSel  (s_reg.sensSel),
    .sensAll  (sensAll),
    .sensData (sensData)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_next            = s_reg;
    wr                = hostReq.wrEn;
    // Engine status may sit on another clock, so two stages first
    s_next.touchSync1 = touchIn;
    s_next.touch      = s_reg.touchSync1;
    s_next.noiseSync1 = noiseIn;
    s_next.noise      = s_reg.noiseSync1;
    s_next.strobe     = 1'b0;
    if (s_reg.cmd && refWrDone) begin
      s_next.cmd = 1'b0;
    end
    if (wr) begin
      case (hostReq.addr)
        ADDR_CAL_FREEZE_1: s_next.freeze[7:0]   = hostReq.wrData;
        ADDR_CAL_FREEZE_2: s_next.freeze[14:8]  = hostReq.wrData[7:1];
        ADDR_CAL_FREEZE_3: s_next.freeze[20:15] = hostReq.wrData[5:0];
        ADDR_NOISE_THRESH: begin
          s_next.nLevel = hostReq.wrData[NOISE_LVL_W-1:0];
          s_next.nCount = hostReq.wrData[NOISE_CNT_LSB +: NOISE_CNT_W];
        end
        ADDR_REF_VAL_HIGH: begin
          // Engine is still copying the value, a change now would corrupt it
          if (!s_reg.cmd) begin
            s_next.refHigh = hostReq.wrData[REF_HIGH_W-1:0];
          end
        end
        ADDR_REF_VAL_LOW: begin
          if (!s_reg.cmd) begin
            s_next.refLow = hostReq.wrData;
          end
        end
        ADDR_REF_TGT_1: s_next.target[6:0]   = hostReq.wrData[7:1];
        ADDR_REF_TGT_2: begin
          s_next.target[7]    = hostReq.wrData[0];
          s_next.target[13:8] = hostReq.wrData[7:2];
        end
        ADDR_REF_TGT_3: begin
          s_next.target[20:14] = hostReq.wrData[6:0];
          if (hostReq.wrData[REF_CMD_BIT] && !s_reg.cmd) begin
            s_next.cmd    = 1'b1;
            s_next.strobe = 1'b1;
          end
        end
        ADDR_SENS_SEL: s_next.sensSel = hostReq.wrData[SEL_W-1:0];
        default: begin
        end
      endcase
    end
    // Read data latched on the read request, one cycle later on rdData
    s_next.rd = RST_ZERO;
    if (hostReq.rdEn) begin
      case (hostReq.addr)
        ADDR_CAL_FREEZE_1: s_next.rd = s_reg.freeze[7:0];
        ADDR_CAL_FREEZE_2: s_next.rd = {s_reg.freeze[14:8], 1'b0};
        ADDR_CAL_FREEZE_3: s_next.rd = {2'b00, s_reg.freeze[20:15]};
        ADDR_NOISE_THRESH: s_next.rd = {3'b000, s_reg.nCount, s_reg.nLevel};
        ADDR_TOUCH_RES_1:  s_next.rd = {1'b0, s_reg.touch[6:0]};
        ADDR_TOUCH_RES_2:  s_next.rd = s_reg.touch[14:7];
        ADDR_TOUCH_RES_3:  s_next.rd = {2'b00, s_reg.noise, s_reg.touch[19:15]};
        ADDR_REF_VAL_HIGH: s_next.rd = {2'b00, s_reg.refHigh};
        ADDR_REF_VAL_LOW:  s_next.rd = s_reg.refLow;
        ADDR_REF_TGT_1:    s_next.rd = {s_reg.target[6:0], 1'b0};
        ADDR_REF_TGT_2:    s_next.rd = {s_reg.target[13:8], 1'b0, s_reg.target[7]};
        ADDR_REF_TGT_3:    s_next.rd = {s_reg.cmd, s_reg.target[20:14]};
        ADDR_SENS_SEL:     s_next.rd = {3'b000, s_reg.sensSel};
        ADDR_SENS_VAL:     s_next.rd = sensData;
        default:           s_next.rd = RST_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.nLevel <= RST_NOISE_LVL;
      s_reg.nCount <= RST_NOISE_CNT;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdData       = s_reg.rd;
  assign calFreeze    = s_reg.freeze;
  assign noiseLevel   = s_reg.nLevel;
  assign noiseCount   = s_reg.nCount;
  assign refWr.strobe = s_reg.strobe;
  assign refWr.target = s_reg.target;
  assign refWr.value  = {s_reg.refHigh, s_reg.refLow};

  // ==========================================================================
  // Assertions
  sequence s_cmd_write;
    hostReq.wrEn && hostReq.addr == ADDR_REF_TGT_3 && hostReq.wrData[REF_CMD_BIT] && !s_reg.cmd;
  endsequence

  property p_cmd_strobe;
    @(posedge clk_sys) disable iff (!rst_n)
      s_cmd_write |=> (refWr.strobe && s_reg.cmd) ##1 !refWr.strobe;
  endproperty
  a_cmd_strobe: assert property (p_cmd_strobe) else $error("command gave no strobe");

  property p_ref_locked;
    @(posedge clk_sys) disable iff (!rst_n)
      (s_reg.cmd && hostReq.wrEn && hostReq.addr == ADDR_REF_VAL_LOW) |=> $stable(refWr.value);
  endproperty
  a_ref_locked: assert property (p_ref_locked) else $error("reference changed while busy");

  property p_ref_low_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (!s_reg.cmd && hostReq.wrEn && hostReq.addr == ADDR_REF_VAL_LOW)
        |=> (refWr.value[7:0] == $past(hostReq.wrData));
  endproperty
  a_ref_low_write: assert property (p_ref_low_write) else $error("low count not stored");

  property p_freeze1;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_CAL_FREEZE_1)
        |=> (calFreeze[7:0] == $past(hostReq.wrData));
  endproperty
  a_freeze1: assert property (p_freeze1) else $error("freeze bits not stored");

  property p_freeze2_lsb;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == ADDR_CAL_FREEZE_2) |=> (rdData[0] == 1'b0);
  endproperty
  a_freeze2_lsb: assert property (p_freeze2_lsb) else $error("reserved bit set");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == 8'h18) |=> (rdData == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_touch_path;
    @(posedge clk_sys) disable iff (!rst_n)
      ##2 (s_reg.touch == $past(touchIn, 2));
  endproperty
  a_touch_path: assert property (p_touch_path) else $error("touch result lag wrong");

  property p_noise_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == ADDR_TOUCH_RES_3)
        |=> (rdData[NOISE_FLAG_BIT] == $past(s_reg.noise));
  endproperty
  a_noise_read: assert property (p_noise_read) else $error("noise flag misplaced");

  property p_reset_vals;
    @(posedge clk_sys) !rst_n |=> (noiseLevel == RST_NOISE_LVL && noiseCount == RST_NOISE_CNT
                                   && calFreeze == '0 && !refWr.strobe);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_noise_fields;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_NOISE_THRESH)
        |=> (noiseLevel == $past(hostReq.wrData[1:0]) && noiseCount == $past(hostReq.wrData[4:2]));
  endproperty
  a_noise_fields: assert property (p_noise_fields) else $error("noise fields wrong");

  // ==========================================================================
  // Command life cycle and further write and read paths
  sequence s_busy_cmd;
    s_reg.cmd && hostReq.wrEn && hostReq.addr == ADDR_REF_TGT_3 && hostReq.wrData[REF_CMD_BIT];
  endsequence

  property p_cmd_refused;
    @(posedge clk_sys) disable iff (!rst_n)
      s_busy_cmd |=> !refWr.strobe;
  endproperty
  a_cmd_refused: assert property (p_cmd_refused) else $error("command taken while busy");

  property p_cmd_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (s_reg.cmd && refWrDone) |=> !s_reg.cmd;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command bit stuck");

  property p_strobe_single;
    @(posedge clk_sys) disable iff (!rst_n)
      refWr.strobe |=> !refWr.strobe;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("strobe held too long");

  property p_ref_high_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (!s_reg.cmd && hostReq.wrEn && hostReq.addr == ADDR_REF_VAL_HIGH)
        |=> (refWr.value[REF_W-1:REF_W-REF_HIGH_W] == $past(hostReq.wrData[REF_HIGH_W-1:0]));
  endproperty
  a_ref_high_write: assert property (p_ref_high_write) else $error("high count lost");

  property p_target1_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_REF_TGT_1)
        |=> (refWr.target[6:0] == $past(hostReq.wrData[7:1]));
  endproperty
  a_target1_write: assert property (p_target1_write) else $error("target bits lost");

  property p_target3_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_REF_TGT_3)
        |=> (refWr.target[20:14] == $past(hostReq.wrData[6:0]));
  endproperty
  a_target3_write: assert property (p_target3_write) else $error("target bits lost");

  property p_freeze2_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_CAL_FREEZE_2)
        |=> (calFreeze[14:8] == $past(hostReq.wrData[7:1]));
  endproperty
  a_freeze2_write: assert property (p_freeze2_write) else $error("freeze bits lost");

  property p_freeze3_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.wrEn && hostReq.addr == ADDR_CAL_FREEZE_3)
        |=> (calFreeze[20:15] == $past(hostReq.wrData[5:0]));
  endproperty
  a_freeze3_write: assert property (p_freeze3_write) else $error("freeze bits lost");

  property p_touch_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == ADDR_TOUCH_RES_1)
        |=> (rdData == {1'b0, $past(s_reg.touch[6:0])});
  endproperty
  a_touch_read: assert property (p_touch_read) else $error("touch read wrong");

  property p_sens_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostReq.rdEn && hostReq.addr == ADDR_SENS_VAL)
        |=> (rdData == $past(sensData));
  endproperty
  a_sens_read: assert property (p_sens_read) else $error("sensitivity read wrong");

  property p_noise_path;
    @(posedge clk_sys) disable iff (!rst_n)
      ##2 (s_reg.noise == $past(noiseIn, 2));
  endproperty
  a_noise_path: assert property (p_noise_path) else $error("noise flag lag wrong");

endmodule : tcor_regs

// ==== rtl/tcor_sens_mux.sv ====
// Channel selector decode and registered sensitivity readback
`timescale 1ns/100ps
module tcor_sens_mux #(
  parameter int NCH  = 20,
  parameter int SW   = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [4:0]       chanSel,
  input  wire logic [NCH*SW-1:0] sensAll,
  output logic      [SW-1:0]    sensData
);
  import tcor_pkg::*;

  typedef struct packed {
    logic [SW-1:0] data;
  } tcor_mux_state_t;

  tcor_mux_state_t state_reg;
  tcor_mux_state_t state_next;
  logic [SEL_W-1:0] idx;

  // ==========================================================================
  // Decode: codes 1..7 -> channel 1..7, 9..21 -> channel 8..20, others read 0
  always_comb begin
    state_next = '{data: '0};
    idx        = '0;
    if (chanSel != '0 && chanSel <= SEL_CH7) begin
      idx             = chanSel - 5'h01;
      state_next.data = sensAll[idx*SW +: SW];
    end else if (chanSel > SEL_UNUSED && chanSel <= SEL_CH20) begin
      idx             = chanSel - 5'h02;
      state_next.data = sensAll[idx*SW +: SW];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '{data: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sensData = state_reg.data;

  property p_sel_gap;
    @(posedge clk_sys) disable iff (!rst_n)
      (chanSel == SEL_UNUSED || chanSel == '0) |=> (sensData == '0);
  endproperty
  a_sel_gap: assert property (p_sel_gap) else $error("gap code returned data");

  property p_sel_ch1;
    @(posedge clk_sys) disable iff (!rst_n)
      (chanSel == 5'h01) |=> (sensData == $past(sensAll[SW-1:0]));
  endproperty
  a_sel_ch1: assert property (p_sel_ch1) else $error("channel 1 readback wrong");

endmodule : tcor_sens_mux

// ==== sim/tcor_engine_model.sv ====
// Calibration engine stand-in: takes reference loads and reports completion
`timescale 1ns/100ps
module tcor_engine_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire tcor_pkg::tcor_ref_wr_t refWr,
  input  wire logic [7:0]             doneDelay,
  output logic                        refWrDone,
  output logic [7:0]                  loadCount,
  output tcor_pkg::tcor_ref_wr_t      lastLoad
);
  import tcor_pkg::*;
  logic [7:0] waitCnt;
  logic       busy;
  // ==========================================================================
  // Load engine
  // Busy for doneDelay+1 cycles; counting strobes exposes a strobe held too long
  always_ff @(posedge clk_sys) begin
    refWrDone <= 1'b0;
    if (!rst_n) begin
      busy      <= 1'b0;
      waitCnt   <= 8'h00;
      loadCount <= 8'h00;
      lastLoad  <= '0;
    end else if (refWr.strobe) begin
      busy      <= 1'b1;
      waitCnt   <= doneDelay;
      loadCount <= loadCount + 8'h01;
      lastLoad  <= refWr;
    end else if (busy && waitCnt == 8'h00) begin
      busy      <= 1'b0;
      refWrDone <= 1'b1;
    end else if (busy) begin
      waitCnt <= waitCnt - 8'h01;
    end
  end
endmodule : tcor_engine_model

// ==== sim/testbench.sv ====
// Self-checking bench for the touch calibration and output register bank
`timescale 1ns/100ps
module testbench;
  import tcor_pkg::*;
  // ==========================================================================
  // Signals
  logic           clk_sys, rst_n, noiseIn, refWrDone;
  tcor_host_req_t hostReq;
  logic [7:0]     rdData, doneDelay, loadCount, rd, t3;
  logic [19:0]    touchIn;
  logic [159:0]   sensAll;
  logic [20:0]    calFreeze;
  logic [1:0]     noiseLevel;
  logic [2:0]     noiseCount;
  tcor_ref_wr_t   refWr, lastLoad;
  logic [31:0]    seed, d, e;
  int             n_errors, cmp_count;

  tcor_regs #(.NCH(20)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hostReq(hostReq),
    .rdData(rdData), .touchIn(touchIn), .noiseIn(noiseIn), .sensAll(sensAll),
    .refWrDone(refWrDone), .calFreeze(calFreeze), .noiseLevel(noiseLevel),
    .noiseCount(noiseCount), .refWr(refWr));
  tcor_engine_model engine_u (.clk_sys(clk_sys), .rst_n(rst_n), .refWr(refWr),
    .doneDelay(doneDelay), .refWrDone(refWrDone), .loadCount(loadCount), .lastLoad(lastLoad));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
    return seed;
  endfunction : rnd
  // Selector code 8 is a hole, so channels 8 and up sit one code higher
  function automatic logic [7:0] sensExp(input logic [7:0] s);
    if (s >= 1 && s <= 7) return sensAll[(s-1)*8 +: 8];
    if (s >= 9 && s <= 21) return sensAll[(s-2)*8 +: 8];
    return 8'h00;
  endfunction : sensExp
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    hostReq = '{1'b1, 1'b0, a, v};
    @(negedge clk_sys);
    hostReq.wrEn = 1'b0;
  endtask : wr
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    hostReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    hostReq.rdEn = 1'b0;
    v = rdData;
  endtask : rdv
  task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rdv(a, v);
    chk(name, v, exp);
  endtask : rdChk
  task automatic doReset();
    rst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
  endtask : doReset
  // Unmapped holes 0x18-0x1f are swept too
  task automatic resetCheck();
    for (int a = 8'h14; a <= 8'h2a; a++) begin
      rdChk("reset value", a[7:0], (a == 8'h17) ? 8'h0d : 8'h00);
    end
    chk("calFreeze", calFreeze, 0);
    chk("noiseLevel", noiseLevel, 1);
    chk("noiseCount", noiseCount, 3);
  endtask : resetCheck
  task automatic summarize();
    $display("Comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    seed = 32'h7fc0_c344;
    hostReq = '0;
    rst_n = 1'b0;
    touchIn = '0;
    noiseIn = 1'b0;
    doneDelay = 8'h05;
    for (int i = 0; i < 5; i++) sensAll[i*32 +: 32] = rnd();
    doReset();
    resetCheck();
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffff_ffff : rnd();
      wr(ADDR_CAL_FREEZE_1, d[7:0]);
      wr(ADDR_CAL_FREEZE_2, d[15:8]);
      wr(ADDR_CAL_FREEZE_3, d[23:16]);
      rdChk("freeze2", ADDR_CAL_FREEZE_2, d[15:8] & 8'hfe);
      rdChk("freeze3", ADDR_CAL_FREEZE_3, d[23:16] & 8'h3f);
      chk("calFreeze", calFreeze, {d[21:16], d[15:9], d[7:0]});
      wr(ADDR_NOISE_THRESH, d[31:24]);
      rdChk("noise ctrl", ADDR_NOISE_THRESH, d[31:24] & 8'h1f);
      chk("noiseLevel", noiseLevel, d[25:24]);
      chk("noiseCount", noiseCount, d[28:26]);
      rdChk("unmapped", 8'h18 + i[7:0], 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hffff_ffff : rnd();
      touchIn = d[19:0];
      noiseIn = d[20];
      wr(ADDR_TOUCH_RES_3, ~d[27:20]);
      repeat (3) @(negedge clk_sys);
      rdChk("touch1", ADDR_TOUCH_RES_1, {1'b0, d[6:0]});
      rdChk("touch2", ADDR_TOUCH_RES_2, d[14:7]);
      rdChk("touch3", ADDR_TOUCH_RES_3, {2'b00, d[20:15]});
    end
    // Slow engine first so the busy window can be probed, then a prompt one
    for (int k = 0; k < 2; k++) begin
      doneDelay = k ? 8'h00 : 8'h28;
      d = rnd();
      e = rnd();
      t3 = {1'b1, e[6:0]};
      wr(ADDR_REF_VAL_HIGH, d[7:0]);
      wr(ADDR_REF_VAL_LOW, d[15:8]);
      wr(ADDR_REF_TGT_1, d[23:16]);
      wr(ADDR_REF_TGT_2, d[31:24]);
      wr(ADDR_REF_TGT_3, t3);
      if (k == 0) begin
        rdChk("command busy", ADDR_REF_TGT_3, t3);
        wr(ADDR_REF_VAL_HIGH, ~d[7:0]);
        wr(ADDR_REF_VAL_LOW, ~d[15:8]);
        t3 = {1'b1, ~e[6:0]};
        wr(ADDR_REF_TGT_3, t3);
      end
      rdChk("ref high", ADDR_REF_VAL_HIGH, {2'b00, d[5:0]});
      rdChk("ref low", ADDR_REF_VAL_LOW, d[15:8]);
      rdChk("target1", ADDR_REF_TGT_1, d[23:16] & 8'hfe);
      rdChk("target2", ADDR_REF_TGT_2, d[31:24] & 8'hfd);
      rd = 8'h80;
      for (int n = 0; n < 100 && rd[7]; n++) rdv(ADDR_REF_TGT_3, rd);
      chk("command cleared", rd, {1'b0, t3[6:0]});
      chk("load count", loadCount, k + 1);
      chk("load value", lastLoad.value, {d[5:0], d[15:8]});
      chk("load target", lastLoad.target, {e[6:0], d[31:26], d[24], d[23:17]});
    end
    for (int s = 0; s < 32; s++) begin
      d = rnd();
      wr(ADDR_SENS_SEL, {d[2:0], s[4:0]});
      repeat (2) @(negedge clk_sys);
      rdChk("sens select", ADDR_SENS_SEL, {3'b000, s[4:0]});
      rdChk("sens value", ADDR_SENS_VAL, sensExp(s[7:0]));
    end
    wr(ADDR_SENS_SEL, 8'h01);
    wr(ADDR_SENS_VAL, ~sensExp(8'h01));
    rdChk("sens value ro", ADDR_SENS_VAL, sensExp(8'h01));
    touchIn = '0;
    noiseIn = 1'b0;
    wr(ADDR_CAL_FREEZE_1, 8'h5a);
    doReset();
    resetCheck();
    summarize();
  end
endmodule : testbench
